// file: rtl/asr_readout.sv
// Purpose: clock source select, filter restart and parallel readout control
// Assumes: clk_sys is the master clock; filter datapath runs on the same clock
// Notes: all pins pass a two-flop synchroniser, so pin effects lag two cycles, the registered bus enable three
// Summary of operation
// - oscillator disable high stops the oscillator; master clock comes from outside.
// - rising edge of restart input clears the filter sequencer counter to zero.
// - filter stays in reset while restart is high, released when sampled low.
// - first edge sampling restart low leaves reset and starts collecting samples.
// - converters sharing clock and restart load output registers in the same cycle.
// - after a restart the ready strobe stays high until settled valid data exists.
// - in serial modes either restart or frame align input synchronises converters.
// - with chip select and read both low the data bits are driven continuously.
// - ready strobe goes high two cycles before each new word is loaded.
// - falling edge of the ready strobe marks a new word available.
// - parallel data outputs are three-state so converters can share a bus.
// - output word is twos complement in unipolar and bipolar modes alike.
`timescale 1ns/1ps
module asr_readout (
    input wire logic clk_sys, // master clock, 10 MHz
    input wire logic sys_rst, // async reset, active high
    input wire logic oscillator_disable, // pin: high selects external clock
    output logic osc_enable, // runs the on-chip oscillator
    output logic clk_src_ext, // master clock taken from outside
    input wire logic restart_in, // pin: filter restart
    input wire logic frame_align_in, // pin: serial frame alignment
    input wire logic serial_mode, // pin: high for any serial mode
    input wire logic osr32_sel, // pin: high for 32x, low for 16x
    output logic filter_rst, // holds the decimation filter in reset
    output logic [asr_pkg::SEQ_W-1:0] seq_phase, // filter sequencer count
    input asr_pkg::asr_word_t filt_word, // filtered result
    input wire logic filt_valid, // filt_word present
    output logic filt_ready, // buffer can take filt_word
    input wire logic cs_n, // pin: chip select, active low
    input wire logic rd_n, // pin: read strobe, active low
    output logic [asr_pkg::WORD_W-1:0] pdata_o, // parallel data out
    output logic pdata_oe_n, // low while pdata_o drives the bus
    output logic result_valid_n, // data-ready strobe, active low
    output logic settling // filter settling after a restart
);
    asr_pkg::asr_pins_t pin_meta_q;
    asr_pkg::asr_pins_t pin_q;
    logic restart_prev_q;
    logic frame_prev_q;
    logic frame_seen_q;
    logic [asr_pkg::SEQ_W-1:0] seq_q;
    logic [asr_pkg::SEQ_W-1:0] seq_d;
    logic [asr_pkg::SETTLE_W-1:0] settle_q;
    logic [asr_pkg::SETTLE_W-1:0] settle_d;
    asr_pkg::asr_state_t state_q;
    asr_pkg::asr_state_t state_d;
    logic [asr_pkg::WORD_W-1:0] out_q;
    logic rv_n_q;
    logic rv_n_d;
    logic oe_n_q;
    asr_pkg::asr_word_t buf_word;
    logic buf_valid;

    // sequencer end-of-period for the selected oversampling ratio
    function automatic logic [asr_pkg::SEQ_W-1:0] last_phase(input logic osr32);
        last_phase = osr32 ? asr_pkg::SEQ_LAST_32 : asr_pkg::SEQ_LAST_16;
    endfunction : last_phase

    // phase a given number of cycles before the period end
    function automatic logic [asr_pkg::SEQ_W-1:0] phase_before(
        input logic osr32,
        input logic [asr_pkg::SEQ_W-1:0] lead
    );
        phase_before = last_phase(osr32) - lead;
    endfunction : phase_before

    // two-flop synchroniser; only pin_q is read by logic
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pin_meta_q <= asr_pkg::PINS_RST;
            pin_q <= asr_pkg::PINS_RST;
        end else begin
            pin_meta_q <= '{osc_dis: oscillator_disable, restart: restart_in,
                            frame_align: frame_align_in, serial_mode: serial_mode,
                            osr32: osr32_sel, cs_n: cs_n, rd_n: rd_n};
            pin_q <= pin_meta_q;
        end
    end

    // crystal path only when disable is low; the pin itself is the board's job
    assign osc_enable = !pin_q.osc_dis;
    assign clk_src_ext = pin_q.osc_dis;

    // restart edge and level; a one-cycle pulse is caught as a single high sample
    wire logic restart_rise = pin_q.restart && !restart_prev_q;
    // frame align only counts in serial modes; periodic pulses on phase zero are ignored
    wire logic frame_rise = pin_q.frame_align && !frame_prev_q;
    wire logic frame_aligned = frame_seen_q && (seq_q == asr_pkg::SEQ_ZERO);
    wire logic frame_resync = pin_q.serial_mode && frame_rise && !frame_aligned;
    // reset level lasts while restart is sampled high, released on a low sample
    wire logic restart_hold = pin_q.restart || frame_resync;

    assign filter_rst = restart_hold;
    assign seq_phase = seq_q;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            restart_prev_q <= 1'b0;
            frame_prev_q <= 1'b0;
            frame_seen_q <= 1'b0;
        end else begin
            restart_prev_q <= pin_q.restart;
            frame_prev_q <= pin_q.frame_align;
            frame_seen_q <= frame_seen_q || frame_resync;
        end
    end

    wire logic seq_at_last = (seq_q == last_phase(pin_q.osr32));
    wire logic seq_at_lead = (seq_q == phase_before(pin_q.osr32, asr_pkg::STROBE_LEAD));

    // sequencer cleared and held at zero through reset, counts from the first low sample
    always_comb begin
        if (restart_hold || restart_rise) begin
            seq_d = asr_pkg::SEQ_ZERO;
        end else if (seq_at_last) begin
            seq_d = asr_pkg::SEQ_ZERO;
        end else begin
            seq_d = seq_q + asr_pkg::SEQ_ONE;
        end
    end

    // words after a restart are stale filter output and are discarded
    wire logic settling_now = (settle_q != asr_pkg::SETTLE_NONE);
    wire logic drop_word = settling_now && buf_valid && seq_at_last;
    // load lands on the sequencer wrap, so parts on one clock and restart load together
    wire logic load_word = (state_q == asr_pkg::ST_STROBE2) && seq_at_last;
    wire logic buf_pop = load_word || drop_word;

    assign settling = settling_now;

    always_comb begin
        if (restart_hold) begin
            settle_d = asr_pkg::SETTLE_WORDS;
        end else if (drop_word) begin
            settle_d = settle_q - asr_pkg::SETTLE_ONE;
        end else begin
            settle_d = settle_q;
        end
    end

    // strobe sequence: two high cycles, then load and fall together
    always_comb begin
        state_d = state_q;
        case (state_q)
            asr_pkg::ST_IDLE: begin
                if (!restart_hold && !settling_now && buf_valid && seq_at_lead) begin
                    state_d = asr_pkg::ST_STROBE1;
                end
            end
            asr_pkg::ST_STROBE1: begin
                state_d = asr_pkg::ST_STROBE2;
            end
            asr_pkg::ST_STROBE2: begin
                state_d = asr_pkg::ST_IDLE;
            end
            default: begin
                state_d = asr_pkg::ST_IDLE;
            end
        endcase
        if (restart_hold) begin
            state_d = asr_pkg::ST_IDLE;
        end
    end

    // strobe high while settling or strobing; falls only when a word is loaded
    always_comb begin
        if (settle_d != asr_pkg::SETTLE_NONE || state_d != asr_pkg::ST_IDLE) begin
            rv_n_d = 1'b1;
        end else if (load_word) begin
            rv_n_d = 1'b0;
        end else begin
            rv_n_d = rv_n_q;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            seq_q <= asr_pkg::SEQ_ZERO;
            settle_q <= asr_pkg::SETTLE_WORDS;
            state_q <= asr_pkg::ST_IDLE;
            rv_n_q <= 1'b1;
        end else begin
            seq_q <= seq_d;
            settle_q <= settle_d;
            state_q <= state_d;
            rv_n_q <= rv_n_d;
        end
    end

    // filter code passes unchanged: it is twos complement in either input mode
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            out_q <= asr_pkg::OUT_RST;
        end else if (load_word) begin
            out_q <= buf_word.code;
        end
    end

    // enable registered so the bus driver never glitches on pin skew
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            oe_n_q <= 1'b1;
        end else begin
            oe_n_q <= pin_q.cs_n || pin_q.rd_n;
        end
    end

    assign pdata_o = out_q;
    assign pdata_oe_n = oe_n_q;
    assign result_valid_n = rv_n_q;

    // a receiver stall holds the word here; the filter sees filt_ready low
    asr_buf2 u_buf (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .flush(restart_hold),
        .in_word(filt_word),
        .in_valid(filt_valid),
        .in_ready(filt_ready),
        .out_word(buf_word),
        .out_valid(buf_valid),
        .out_ready(buf_pop)
    );

endmodule : asr_readout

// file: rtl/asr_pkg.sv
// Purpose: shared constants and types for the converter sync and readout control
// Assumes: clk_sys is the converter master clock, 10 MHz
// Notes: phases count master-clock cycles within one output word period
package asr_pkg;

    localparam int WORD_W = 16;
    localparam int SEQ_W = 5;
    localparam int SETTLE_W = 4;

    // decimation period ends: 32x and 16x oversampling
    localparam logic [SEQ_W-1:0] SEQ_ZERO = 5'h00;
    localparam logic [SEQ_W-1:0] SEQ_LAST_32 = 5'h1f;
    localparam logic [SEQ_W-1:0] SEQ_LAST_16 = 5'h0f;
    localparam logic [SEQ_W-1:0] SEQ_ONE = 5'h01;
    // strobe rises this many cycles before the load edge
    localparam logic [SEQ_W-1:0] STROBE_LEAD = 5'h02;

    // words discarded after a restart while the filter settles
    localparam logic [SETTLE_W-1:0] SETTLE_WORDS = 4'h8;
    localparam logic [SETTLE_W-1:0] SETTLE_NONE = 4'h0;
    localparam logic [SETTLE_W-1:0] SETTLE_ONE = 4'h1;

    localparam logic [WORD_W-1:0] OUT_RST = 16'h0000;

    // twos complement result word from the decimation filter
    typedef struct packed {
        logic [WORD_W-1:0] code;
    } asr_word_t;

    // asynchronous pins, carried together through the synchroniser
    typedef struct packed {
        logic osc_dis;
        logic restart;
        logic frame_align;
        logic serial_mode;
        logic osr32;
        logic cs_n;
        logic rd_n;
    } asr_pins_t;

    localparam asr_pins_t PINS_RST = '{osc_dis: 1'b0, restart: 1'b0, frame_align: 1'b0,
                                       serial_mode: 1'b0, osr32: 1'b0, cs_n: 1'b1,
                                       rd_n: 1'b1};

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_STROBE1 = 2'b01,
        ST_STROBE2 = 2'b11
    } asr_state_t;

endpackage : asr_pkg

// file: rtl/asr_buf2.sv
// Purpose: two-entry word buffer between filter and output register
// Assumes: single clock, flush empties it in one cycle
// Notes: in_ready falls only when both entries hold words
`timescale 1ns/1ps
module asr_buf2 (
    input wire logic clk_sys, // master clock
    input wire logic sys_rst, // async reset, active high
    input wire logic flush, // drop all held words
    input asr_pkg::asr_word_t in_word, // word from filter
    input wire logic in_valid, // in_word present
    output logic in_ready, // room for a word
    output asr_pkg::asr_word_t out_word, // oldest held word
    output logic out_valid, // out_word present
    input wire logic out_ready // drain side takes out_word
);
    asr_pkg::asr_word_t mem_q [2];
    logic wr_ptr_q;
    logic rd_ptr_q;
    logic [1:0] count_q;
    wire logic push = in_valid && in_ready;
    wire logic pop = out_valid && out_ready;

    assign in_ready = (count_q != 2'h2);
    assign out_valid = (count_q != 2'h0);
    assign out_word = mem_q[rd_ptr_q];

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q <= 2'h0;
        end else if (flush) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q <= 2'h0;
        end else begin
            wr_ptr_q <= wr_ptr_q ^ push;
            rd_ptr_q <= rd_ptr_q ^ pop;
            count_q <= count_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // storage needs no reset; out_valid guards every read
    always_ff @(posedge clk_sys) begin
        if (push && !flush) begin
            mem_q[wr_ptr_q] <= in_word;
        end
    end

endmodule : asr_buf2

// file: testbench/asr_readout_props.sv
// Purpose: port-level checks for asr_readout
// Assumes: pins pass a two-flop synchroniser inside the block
// Notes: pin repetition counts leave a cycle of slack over the sync lag
`timescale 1ns/1ps
module asr_readout_chk (
    input wire logic clk_sys, // clock
    input wire logic sys_rst, // reset
    input wire logic oscillator_disable, // pin
    input wire logic osc_enable, // out
    input wire logic clk_src_ext, // out
    input wire logic restart_in, // pin
    input wire logic cs_n, // pin
    input wire logic rd_n, // pin
    input wire logic filter_rst, // out
    input wire logic [asr_pkg::SEQ_W-1:0] seq_phase, // out
    input wire logic [asr_pkg::WORD_W-1:0] pdata_o, // out
    input wire logic pdata_oe_n, // out
    input wire logic result_valid_n, // out
    input wire logic settling // out
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    // a restart landing mid-strobe reloads settling and keeps the strobe high
    sequence s_strobe;
        result_valid_n [*2] ##1 (!result_valid_n || settling);
    endsequence
    sequence s_release;
        seq_phase == asr_pkg::SEQ_ZERO ##1 seq_phase == asr_pkg::SEQ_ONE;
    endsequence
    a_restart_holds: assert property (restart_in [*3] |=> filter_rst)
        else $error("filter left reset while restart high");
    a_rst_seq_zero: assert property (filter_rst |=> seq_phase == asr_pkg::SEQ_ZERO)
        else $error("sequencer not cleared");
    a_release_count: assert property ($fell(filter_rst) |-> s_release)
        else $error("sequencer did not start on release");
    a_strobe_two: assert property ($rose(result_valid_n) && !settling |-> s_strobe)
        else $error("strobe width wrong");
    a_load_at_wrap: assert property ($fell(result_valid_n) |->
        seq_phase == asr_pkg::SEQ_ZERO && $past(result_valid_n, 2))
        else $error("load not at wrap after strobe");
    a_word_on_fall: assert property ($changed(pdata_o) |-> $fell(result_valid_n))
        else $error("output word changed without strobe");
    a_settle_quiet: assert property (settling |-> result_valid_n)
        else $error("strobe low while settling");
    a_bus_float: assert property ((cs_n || rd_n) [*4] |=> pdata_oe_n)
        else $error("bus driven while deselected");
    a_bus_drive: assert property ((!cs_n && !rd_n) [*4] |=> !pdata_oe_n)
        else $error("bus not driven while selected");
    a_ext_clock: assert property (oscillator_disable [*3] |=> clk_src_ext && !osc_enable)
        else $error("oscillator still enabled");
endmodule : asr_readout_chk
bind asr_readout asr_readout_chk u_chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .oscillator_disable(oscillator_disable),
    .osc_enable(osc_enable), .clk_src_ext(clk_src_ext), .restart_in(restart_in),
    .cs_n(cs_n), .rd_n(rd_n), .filter_rst(filter_rst), .seq_phase(seq_phase),
    .pdata_o(pdata_o), .pdata_oe_n(pdata_oe_n), .result_valid_n(result_valid_n),
    .settling(settling)
);

// file: testbench/asr_host_model.sv
// Purpose: host processor reading the parallel bus
// Assumes: strobe edges seen on clk_sys
// Notes: a floating bus reads as the inverse of its last value
`timescale 1ns/1ps
module asr_host_model (
    input wire logic clk_sys, // clock
    input wire logic result_valid_n, // strobe
    input wire logic [15:0] pdata_o, // device data
    input wire logic pdata_oe_n, // device drives when low
    output logic [15:0] lat_word, // taken on strobe rise
    output logic [15:0] rd_word, // taken on strobe fall
    output logic [7:0] rd_cnt // reads done
);
    logic rvn_q = 1'b1;
    logic [15:0] bus_q = 16'h0000;
    logic [15:0] bus;
    logic [7:0] cnt_q = 8'h00;
    assign rd_cnt = cnt_q;
    assign bus = pdata_oe_n ? ~bus_q : pdata_o;
    always @(posedge clk_sys) begin
        rvn_q <= result_valid_n;
        bus_q <= bus;
        if (result_valid_n && !rvn_q) lat_word <= bus;
        if (!result_valid_n && rvn_q) begin
            rd_word <= bus;
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule : asr_host_model

// file: testbench/asr_readout_tb.sv
// Purpose: self-checking bench for asr_readout
// Assumes: host model on the bus, bench drives pins and filter words
// Notes: word codes cross the sign boundary to show pass-through
`timescale 1ns/1ps
module asr_readout_tb;
    logic clk_sys, sys_rst = 1'b1, oscillator_disable = 1'b0, restart_in = 1'b0;
    logic frame_align_in = 1'b0, serial_mode = 1'b0, osr32_sel = 1'b1;
    logic cs_n = 1'b1, rd_n = 1'b1, src_on = 1'b0, saw_full = 1'b0, rvn_q = 1'b1;
    logic osc_enable, clk_src_ext, filter_rst, filt_ready, pdata_oe_n, result_valid_n;
    logic settling;
    logic [4:0] seq_phase;
    logic [15:0] pdata_o, lat_word, rd_word, n_sent = 16'h0000;
    logic [7:0] rd_cnt, gap = 8'h00, last_gap = 8'h00;
    asr_pkg::asr_word_t filt_word;
    int n_fail = 0, num_checks = 0;
    assign filt_word.code = 16'h7ff7 + n_sent;
    asr_readout u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .oscillator_disable(oscillator_disable), .osc_enable(osc_enable),
        .clk_src_ext(clk_src_ext), .restart_in(restart_in), .frame_align_in(frame_align_in),
        .serial_mode(serial_mode), .osr32_sel(osr32_sel), .filter_rst(filter_rst),
        .seq_phase(seq_phase), .filt_word(filt_word), .filt_valid(src_on),
        .filt_ready(filt_ready), .cs_n(cs_n), .rd_n(rd_n), .pdata_o(pdata_o),
        .pdata_oe_n(pdata_oe_n), .result_valid_n(result_valid_n), .settling(settling));
    asr_host_model u_host (.clk_sys(clk_sys), .result_valid_n(result_valid_n),
        .pdata_o(pdata_o), .pdata_oe_n(pdata_oe_n), .lat_word(lat_word),
        .rd_word(rd_word), .rd_cnt(rd_cnt));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        rvn_q <= result_valid_n;
        gap <= gap + 8'h01;
        if (rvn_q && !result_valid_n) begin
            last_gap <= gap;
            gap <= 8'h01;
        end
        if (!src_on) saw_full <= 1'b0;
        else if (!filt_ready) saw_full <= 1'b1;
        if (!src_on) n_sent <= 16'h0000;
        else if (filt_ready) n_sent <= n_sent + 16'h0001;
    end
    task automatic check1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check1
    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check16
    task automatic close_out;
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out
    task automatic t_reset(input int n);
        sys_rst = 1'b1;
        repeat (n) @(posedge clk_sys);
        #1 sys_rst = 1'b0;
        @(posedge clk_sys);
        #1 check1(result_valid_n, 1'b1);
        check1(pdata_oe_n, 1'b1);
        check1(settling, 1'b1);
        check16(pdata_o, asr_pkg::OUT_RST);
    endtask : t_reset
    task automatic t_osc;
        for (int v = 1; v >= 0; v--) begin
            oscillator_disable = v[0];
            repeat (4) @(posedge clk_sys);
            #1 check1(clk_src_ext, v[0]);
            check1(osc_enable, !v[0]);
        end
    endtask : t_osc
    task automatic t_frame;
        logic seen;
        for (int m = 0; m < 2; m++) begin
            serial_mode = m[0];
            repeat (4) @(posedge clk_sys);
            #1 frame_align_in = 1'b1;
            seen = 1'b0;
            repeat (6) begin
                @(posedge clk_sys);
                #1 seen = seen | filter_rst;
            end
            frame_align_in = 1'b0;
            check1(seen, m[0]);
        end
        serial_mode = 1'b0;
        restart_in = 1'b1;
        repeat (5) @(posedge clk_sys);
        #1 check1(filter_rst, 1'b1);
        restart_in = 1'b0;
    endtask : t_frame
    task automatic t_bus;
        for (int p = 0; p < 4; p++) begin
            {cs_n, rd_n} = p[1:0];
            repeat (5) @(posedge clk_sys);
            #1 check1(pdata_oe_n, p != 0);
        end
    endtask : t_bus
    task automatic t_stream(input logic osr);
        int i;
        logic [7:0] c0;
        {cs_n, rd_n, osr32_sel, src_on} = {2'b00, osr, 1'b0};
        restart_in = 1'b1; // one-cycle pulse
        @(posedge clk_sys);
        #1 restart_in = 1'b0;
        for (i = 0; filter_rst !== 1'b1 && i < 6; i++) begin
            @(posedge clk_sys);
            #1;
        end
        check1(filter_rst, 1'b1);
        for (i = 0; filter_rst !== 1'b0 && i < 6; i++) begin
            @(posedge clk_sys);
            #1;
        end
        check1(result_valid_n, 1'b1);
        src_on = 1'b1;
        for (int k = 0; k < 3; k++) begin
            c0 = rd_cnt;
            for (i = 0; rd_cnt == c0 && i < 400; i++) begin
                @(posedge clk_sys);
                #1;
            end
            check16(rd_word, 16'h7ff7 + 16'(8 + k));
            if (k > 0) check16(lat_word, 16'h7ff7 + 16'(7 + k));
        end
        check16({8'h00, last_gap}, osr ? 16'h0020 : 16'h0010);
        check1(saw_full, 1'b1);
        src_on = 1'b0;
        repeat (100) @(posedge clk_sys);
        #1 check1(filt_ready, 1'b1);
    endtask : t_stream
    initial begin
        repeat (6000) @(posedge clk_sys);
        n_fail++;
        close_out();
    end
    initial begin
        t_reset(20);
        t_osc();
        t_frame();
        t_bus();
        t_stream(1'b1);
        t_stream(1'b0);
        t_reset(3);
        close_out();
    end
endmodule : asr_readout_tb
